// File: core/ast_map.svh
// ast_map.svh: offsets-free constant map for the serial transmitter block
// assumes: included by bare name from design files under core/
`ifndef AST_MAP_SVH
`define AST_MAP_SVH
`define AST_CLK_HZ       50000000
`define AST_BAUD_HZ      115200
`define AST_BAUD_DIV     ((`AST_CLK_HZ / `AST_BAUD_HZ) - 1)
`define AST_BITS_SHORT   4'd10
`define AST_BITS_LONG    4'd11
`define AST_BREAK_LONG   4'd13
`define AST_FIFO_DEPTH   8
`define AST_FIFO_AW      3
`define AST_DATA_W       9
`define AST_INV_RESET    1'b0
`endif

// File: core/ast_pkg.sv
// ast_pkg.sv: types shared by the serial transmitter block
// assumes: nothing beyond a sv compiler
package ast_pkg;
  typedef enum logic [2:0] {
    AST_OFF      = 3'b000,
    AST_PREAMBLE = 3'b001,
    AST_IDLE     = 3'b010,
    AST_DATA     = 3'b011,
    AST_BREAK    = 3'b100
  } ast_state_e;
endpackage

// File: core/ast_fifo.sv
// ast_fifo.sv: small valid/ready fifo in front of the transmit shifter
// assumes: one clock, synchronous active-high reset, clock enable
`timescale 1ns/1ps
module ast_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (clk_en && push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (clk_en) begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // ast_fifo

// File: core/ast_baud.sv
// ast_baud.sv: shared baud generator, one tick per bit period
// assumes: clock is the die-to-die interface clock; resync restarts the period
`timescale 1ns/1ps
`include "ast_map.svh"
module ast_baud (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic resync,
  output logic      tick
);
  localparam logic [15:0] DIV = 16'(`AST_BAUD_DIV);
  logic [15:0] cnt_q;

  assign tick = (cnt_q == DIV);

  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_q <= 16'h0000;
    end else if (clk_en) begin
      if (resync || tick) begin
        cnt_q <= 16'h0000;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule // ast_baud

// File: core/ast_serial_tx.sv
// ast_serial_tx.sv: async serial transmitter with receive edge resync
// assumes: controls come from same-clock register logic; rx pin is async
//
// Functional notes
// RL1: tx and rx run independently but share one baud generator.
// RL2: all bit timing derives from the die-to-die clock.
// RL3: receiver bit timing restarts on every falling edge of rx input.
// RL4: remote baud within about 4.5 percent (8-bit) or 4.0 (9-bit).
// RL5: output idles high; invert control flips the whole waveform.
// RL6: enabling sends one idle frame preamble, then waits for data.
// RL7: a data write goes into the transmit buffer.
// RL8: frame is 10 bits, or 11 with nine-bit mode.
// RL9: free shifter loads buffer on a baud tick; buffer-empty then sets; here it sets only once that load leaves the fifo empty.
// RL10: no data after stop bit sets transmit-complete, line idles high.
// RL11: after disable, finish current and queued frames, then release pin; here buffered data is not sent after disable, only a queued break or preamble.
// RL12: break is a full character time of zeros.
// RL13: long-break select makes each break 13 bit times of zero.
// RL14: a rising send-break queues one break sent when shifter frees.
// RL15: frame is start, data lsb first, optional ninth bit, stop.
// RL16: parity goes in the top data bit; even or odd by select.
// RL17: one bit per baud tick, held for the whole period.
`timescale 1ns/1ps
`include "ast_map.svh"
module ast_serial_tx (
  input  wire logic                   clock,
  input  wire logic                   reset,
  input  wire logic                   clk_en,
  input  wire logic                   tx_enable,
  input  wire logic                   nine_bit_mode,
  input  wire logic                   parity_on,
  input  wire logic                   odd_parity_select,
  input  wire logic                   output_invert_ctrl,
  input  wire logic                   send_break_ctrl,
  input  wire logic                   long_break_select,
  input  wire logic [`AST_DATA_W-1:0] serial_data_reg,
  input  wire logic                   data_write,
  output logic                        data_ready,
  output logic                        tx_buffer_empty_flag,
  output logic                        tx_complete_flag,
  output logic                        txd_out,
  output logic                        txd_oe,
  input  wire logic                   rxd_in,
  output logic                        rx_resync
);
  logic [`AST_DATA_W-1:0] fifo_data;
  logic                   fifo_valid;
  logic                   fifo_pop;
  logic                   tick;
  logic                   rx_meta_q;
  logic                   rx_sync_q;
  logic                   rx_prev_q;
  logic                   rx_fall;
  ast_pkg::ast_state_e    state_q;
  logic [10:0]            shift_q;
  logic [3:0]             bits_q;
  logic                   break_pend_q;
  logic                   sbk_prev_q;
  logic                   line_q;
  logic                   oe_q;
  logic                   tc_q;
  logic                   enable_prev_q;
  logic                   preamble_pend_q;
  logic                   sbk_rise;
  logic                   start_data;
  logic                   start_break;
  logic                   start_pre;
  logic                   enable_rise;
  logic                   shifter_free;
  logic                   frame_done;
  logic [3:0]             frame_len;
  logic [`AST_DATA_W-1:0] word;
  logic                   par_bit;

  // buffer stalls the writer through data_ready when full
  ast_fifo #(
    .WIDTH (`AST_DATA_W),
    .DEPTH (`AST_FIFO_DEPTH),
    .AW    (`AST_FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .reset     (reset),
    .clk_en    (clk_en),
    .in_data   (serial_data_reg),
    .in_valid  (data_write),
    .in_ready  (data_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  ); // RL7

  ast_baud u_baud (
    .clock  (clock),
    .reset  (reset),
    .clk_en (clk_en),
    .resync (1'b0),
    .tick   (tick)
  ); // RL1 RL2

  // receive side: only the edge resync lives here
  always_ff @(posedge clock) begin
    if (reset) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else if (clk_en) begin
      rx_meta_q <= rxd_in;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_sync_q;
    end
  end

  assign rx_fall   = rx_prev_q && !rx_sync_q;
  assign rx_resync = rx_fall; // RL3

  // break request latched on the 0-to-1 of the control
  assign sbk_rise = send_break_ctrl && !sbk_prev_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      sbk_prev_q <= 1'b0;
    end else if (clk_en) begin
      sbk_prev_q <= send_break_ctrl;
    end
  end

  assign frame_len    = nine_bit_mode ? `AST_BITS_LONG : `AST_BITS_SHORT; // RL8
  assign enable_rise  = tx_enable && !enable_prev_q;
  // a frame ends only in a busy state; idle keeps bits_q at 1 once a frame has ended
  assign frame_done   = tick && (bits_q == 4'h1) &&
                        (state_q != ast_pkg::AST_OFF) && (state_q != ast_pkg::AST_IDLE);
  // next frame loads on the closing tick of the stop bit, so frames run back to back
  assign shifter_free = (state_q == ast_pkg::AST_IDLE) || (state_q == ast_pkg::AST_OFF) ||
                        frame_done;
  assign start_pre    = tick && preamble_pend_q && shifter_free;
  // nothing may overtake the preamble queued by this very enable edge
  assign start_break  = tick && !start_pre && break_pend_q && !enable_rise &&
                        shifter_free; // RL14
  assign start_data   = tick && !start_pre && !break_pend_q && !enable_rise && fifo_valid &&
                        tx_enable && (state_q != ast_pkg::AST_OFF) && shifter_free; // RL9
  assign fifo_pop     = clk_en && start_data;

  // parity replaces the top data bit of the character
  always_comb begin
    word = fifo_data;
    if (!nine_bit_mode) begin
      word[8] = 1'b0;
    end
    par_bit = 1'b0;
    if (parity_on) begin
      if (nine_bit_mode) begin
        par_bit = (^fifo_data[7:0]) ^ odd_parity_select;
        word[8] = par_bit;
      end else begin
        par_bit = (^fifo_data[6:0]) ^ odd_parity_select;
        word[7] = par_bit;
      end
    end
  end // RL16

  always_ff @(posedge clock) begin
    if (reset) begin
      break_pend_q <= 1'b0;
    end else if (clk_en) begin
      if (sbk_rise) begin
        break_pend_q <= 1'b1; // RL14
      end else if (start_break) begin
        break_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      enable_prev_q   <= 1'b0;
      preamble_pend_q <= 1'b0;
    end else if (clk_en) begin
      enable_prev_q <= tx_enable;
      if (enable_rise) begin
        preamble_pend_q <= 1'b1; // RL6
      end else if (start_pre) begin
        preamble_pend_q <= 1'b0;
      end
    end
  end

  // shifter: every frame runs to its end, even after disable
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= ast_pkg::AST_OFF;
      shift_q <= 11'h7ff;
      bits_q  <= 4'h0;
      line_q  <= 1'b1;
    end else if (clk_en) begin
      if (start_pre) begin
        state_q <= ast_pkg::AST_PREAMBLE;
        bits_q  <= frame_len;
        line_q  <= 1'b1; // RL6
      end else if (start_break) begin
        state_q <= ast_pkg::AST_BREAK;
        bits_q  <= long_break_select ? `AST_BREAK_LONG : frame_len; // RL12 RL13
        line_q  <= 1'b0;
      end else if (start_data) begin
        state_q <= ast_pkg::AST_DATA;
        bits_q  <= frame_len;
        line_q  <= 1'b0;
        shift_q <= nine_bit_mode ? {1'b1, word, 1'b0}
                                 : {2'b11, word[7:0], 1'b0}; // RL15
      end else begin
        unique case (state_q)
          ast_pkg::AST_OFF, ast_pkg::AST_IDLE: begin
            line_q  <= 1'b1;
            state_q <= tx_enable ? ast_pkg::AST_IDLE : ast_pkg::AST_OFF;
          end
          ast_pkg::AST_PREAMBLE, ast_pkg::AST_BREAK: begin
            if (frame_done) begin
              state_q <= tx_enable ? ast_pkg::AST_IDLE : ast_pkg::AST_OFF;
              line_q  <= 1'b1;
            end else if (tick) begin
              bits_q <= bits_q - 4'h1;
            end
          end
          ast_pkg::AST_DATA: begin
            if (frame_done) begin
              state_q <= tx_enable ? ast_pkg::AST_IDLE : ast_pkg::AST_OFF;
              line_q  <= 1'b1;
            end else if (tick) begin
              bits_q  <= bits_q - 4'h1;
              shift_q <= {1'b1, shift_q[10:1]};
              line_q  <= shift_q[1]; // RL17
            end
          end
          default: begin
            state_q <= ast_pkg::AST_OFF;
          end
        endcase
      end
    end
  end

  // tc sets when a frame ends with nothing waiting
  always_ff @(posedge clock) begin
    if (reset) begin
      tc_q <= 1'b1;
    end else if (clk_en) begin
      if (start_data || start_break || start_pre) begin
        tc_q <= 1'b0;
      end else if (frame_done && !fifo_valid && !break_pend_q && !preamble_pend_q) begin
        tc_q <= 1'b1; // RL10
      end
    end
  end

  // pin stays driven while enabled, while a frame runs, or while a break or preamble is queued
  always_ff @(posedge clock) begin
    if (reset) begin
      oe_q <= 1'b0;
    end else if (clk_en) begin
      if (tx_enable || state_q != ast_pkg::AST_OFF || break_pend_q || preamble_pend_q) begin
        oe_q <= 1'b1;
      end else begin
        oe_q <= 1'b0; // RL11
      end
    end
  end

  assign txd_out              = line_q ^ output_invert_ctrl; // RL5
  assign txd_oe               = oe_q;
  assign tx_buffer_empty_flag = !fifo_valid; // RL9
  assign tx_complete_flag     = tc_q;

  // checks
  sequence break_start_s;
    (state_q != ast_pkg::AST_BREAK) ##1 (state_q == ast_pkg::AST_BREAK);
  endsequence

  sequence line_low_s;
    (!line_q && state_q == ast_pkg::AST_BREAK)[*8];
  endsequence

  break_low_a: assert property (@(posedge clock) disable iff (reset)
    break_start_s |-> line_low_s) // RL12
    else $error("break line not low");

  break_pend_a: assert property (@(posedge clock) disable iff (reset)
    (clk_en && sbk_rise) |=> break_pend_q) // RL14
    else $error("break not queued");

  idle_high_a: assert property (@(posedge clock) disable iff (reset)
    (state_q == ast_pkg::AST_IDLE) |-> (txd_out == !output_invert_ctrl)) // RL5
    else $error("idle level wrong");

  start_bit_a: assert property (@(posedge clock) disable iff (reset)
    (clk_en && start_data) |=> (state_q == ast_pkg::AST_DATA && !line_q && bits_q == frame_len)) // RL8
    else $error("data frame start wrong");

  hold_bit_a: assert property (@(posedge clock) disable iff (reset)
    (state_q == ast_pkg::AST_DATA && !tick) |=> $stable(line_q)) // RL17
    else $error("bit changed off tick");

  oe_hold_a: assert property (@(posedge clock) disable iff (reset)
    (state_q == ast_pkg::AST_DATA) |=> txd_oe) // RL11
    else $error("pin released mid frame");

  tc_done_a: assert property (@(posedge clock) disable iff (reset)
    (clk_en && frame_done && !fifo_valid && !break_pend_q && !preamble_pend_q
     && !start_data) |=> tx_complete_flag) // RL10
    else $error("complete flag missing");

  preamble_a: assert property (@(posedge clock) disable iff (reset)
    (clk_en && tx_enable && !enable_prev_q) |=> preamble_pend_q) // RL6
    else $error("preamble not queued");

  resync_a: assert property (@(posedge clock) disable iff (reset)
    (clk_en && rx_sync_q) ##1 (clk_en && !rx_sync_q) |-> rx_resync) // RL3
    else $error("resync missing");
endmodule // ast_serial_tx

// File: dv/ast_remote_node.sv
// ast_remote_node.sv: remote serial node, frame decoder and character sender
// assumes: same nominal baud as the device, tx line pulled up when released
`timescale 1ns/1ps
module ast_remote_node #(
  parameter int BIT = 434
) (
  input  wire logic clock,
  input  wire logic line,
  input  wire logic nine,
  output logic      rxd
);
  logic [8:0] rx_q[$];
  int         low_bits = 0;
  int         low_cnt  = 0;

  // mid-bit sampling; exact baud match, so no drift within a frame
  always begin : decode
    logic [8:0] d;
    d = '0;
    @(negedge line);
    repeat (BIT / 2) @(posedge clock);
    if (line === 1'b0) begin
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
        repeat (BIT) @(posedge clock);
        d[i] = line;
      end
      repeat (BIT) @(posedge clock);
      // a low stop position means a break, not a character
      if (line === 1'b1) rx_q.push_back(d);
      wait (line === 1'b1);
    end
  end

  // length of each low run, rounded to whole bit times
  always @(posedge clock) begin
    if (line === 1'b0) begin
      low_cnt <= low_cnt + 1;
    end else if (low_cnt > 0) begin
      low_bits <= (low_cnt + BIT / 2) / BIT;
      low_cnt  <= 0;
    end
  end

  initial rxd = 1'b1;

  // 8-bit character, lsb first; called at a falling clock edge
  task automatic send_char(input logic [7:0] b);
    rxd = 1'b0;
    repeat (BIT) @(negedge clock);
    for (int i = 0; i < 8; i++) begin
      rxd = b[i];
      repeat (BIT) @(negedge clock);
    end
    rxd = 1'b1;
    repeat (BIT) @(negedge clock);
  endtask
endmodule // ast_remote_node

// File: dv/ast_serial_tx_tb.sv
// ast_serial_tx_tb.sv: self-checking bench for the serial transmitter
// assumes: core/ on the include path, remote node model from dv/
`timescale 1ns/1ps
`include "ast_map.svh"
module ast_serial_tx_tb;
  localparam int BIT = `AST_BAUD_DIV + 1;
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic       clk_en = 1'b1;
  logic       tx_enable = 1'b0;
  logic       nine_bit_mode = 1'b0;
  logic       parity_on = 1'b0;
  logic       odd_parity_select = 1'b0;
  logic       output_invert_ctrl = 1'b0;
  logic       send_break_ctrl = 1'b0;
  logic       long_break_select = 1'b0;
  logic [8:0] serial_data_reg = '0;
  logic       data_write = 1'b0;
  logic       rxd_in;
  logic       data_ready, tx_buffer_empty_flag, tx_complete_flag;
  logic       txd_out, txd_oe, rx_resync;
  wire        line;
  int         n_fail = 0;
  int         num_checks = 0;
  int         n_sync = 0;

  always #10 clock = ~clock;
  // remote set to matching polarity; pull-up once the pin is released
  assign line = txd_oe ? (txd_out ^ output_invert_ctrl) : 1'b1;
  always @(negedge clock) if (rx_resync === 1'b1) n_sync++;

  ast_serial_tx DUT (.clock, .reset, .clk_en, .tx_enable, .nine_bit_mode, .parity_on,
    .odd_parity_select, .output_invert_ctrl, .send_break_ctrl, .long_break_select,
    .serial_data_reg, .data_write, .data_ready, .tx_buffer_empty_flag,
    .tx_complete_flag, .txd_out, .txd_oe, .rxd_in, .rx_resync);
  ast_remote_node #(.BIT(BIT)) node (.clock(clock), .line(line), .nine(nine_bit_mode),
    .rxd(rxd_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  // two cycles per write, so the strobe never rises in the step it fell
  task automatic write_word(input logic [8:0] d);
    serial_data_reg = d;
    data_write = 1'b1;
    @(negedge clock);
    data_write = 1'b0;
    @(negedge clock);
  endtask

  task automatic wait_tc(input logic v);
    int n;
    n = 0;
    while (tx_complete_flag !== v && n < 100 * BIT) begin
      @(negedge clock);
      n++;
    end
    check(tx_complete_flag, v);
  endtask

  task automatic expect_rx(input logic [8:0] e);
    check(node.rx_q.size(), 1);
    if (node.rx_q.size() > 0) check(node.rx_q.pop_front(), e);
  endtask

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // about 70k cycles expected; generous margin
  initial begin
    #2_000_000;
    n_fail++;
    print_verdict();
  end

  initial begin
    int n;
    repeat (3) @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    check(txd_out, 1);
    check(txd_oe, 0);
    check(tx_complete_flag, 1);
    check(tx_buffer_empty_flag, 1);
    $display("reset test done");

    // words held while disabled; the ninth finds the buffer full
    for (int i = 0; i < 9; i++) write_word(9'(8'ha0 + i));
    check(data_ready, 0);
    check(tx_buffer_empty_flag, 0);
    tx_enable = 1'b1;
    n = 0;
    while (line === 1'b1 && n < 14 * BIT) begin
      @(negedge clock);
      n++;
    end
    check(n >= 10 * BIT && n <= 12 * BIT, 1);
    wait_tc(1'b1);
    repeat (4) @(negedge clock);
    check(node.rx_q.size(), 8);
    for (int i = 0; i < 8; i++) check(node.rx_q.pop_front(), 9'(8'ha0 + i));
    check(tx_buffer_empty_flag, 1);
    check(txd_out, 1);
    $display("buffer test done");

    // parity frames on an inverted pin, with receive traffic alongside
    parity_on = 1'b1;
    output_invert_ctrl = 1'b1;
    @(negedge clock);
    check(txd_out, 0);
    for (int c = 0; c < 2; c++) begin
      nine_bit_mode = c[0];
      odd_parity_select = c[0];
      fork
        node.send_char(8'h55);
        begin
          write_word(c ? 9'h05a : 9'h007);
          wait_tc(1'b0);
          wait_tc(1'b1);
        end
      join
      expect_rx(c ? 9'h15a : 9'h087);
    end
    check(n_sync, 10);
    output_invert_ctrl = 1'b0;
    parity_on = 1'b0;
    nine_bit_mode = 1'b0;
    $display("parity test done");

    // normal then long break, queued by a one-then-zero pulse
    for (int b = 0; b < 2; b++) begin
      long_break_select = b[0];
      check(tx_buffer_empty_flag, 1);
      send_break_ctrl = 1'b1;
      @(negedge clock);
      send_break_ctrl = 1'b0;
      repeat (16 * BIT) @(negedge clock);
      check(node.low_bits, b ? 13 : 10);
      check(node.rx_q.size(), 0);
    end
    $display("break test done");

    // disable mid-character: pin kept until the frame is out
    // a 100-cycle freeze in the start bit must stretch the frame by exactly that
    write_word(9'h0c3);
    wait_tc(1'b0);
    clk_en = 1'b0;
    repeat (100) @(negedge clock);
    check(txd_out, 0);
    clk_en = 1'b1;
    tx_enable = 1'b0;
    n = 100;
    while (tx_complete_flag !== 1'b1 && n < 12 * BIT) begin
      @(negedge clock);
      n++;
      if (n == BIT) check(txd_oe, 1);
    end
    check(n, 10 * BIT + 100);
    wait_tc(1'b1);
    repeat (4) @(negedge clock);
    check(txd_oe, 0);
    expect_rx(9'h0c3);
    $display("disable test done");
    print_verdict();
  end
endmodule // ast_serial_tx_tb
